// *** itm_pkg.sv ***
package itm_pkg;
	// Register byte addresses on the APB.
	localparam logic [11:0] ITM_ADDR_TIMER_CTL = 12'h000;
	localparam logic [11:0] ITM_ADDR_CLK_SEL = 12'h004;
	localparam logic [11:0] ITM_ADDR_MATCH = 12'h008;
	localparam logic [11:0] ITM_ADDR_COUNT = 12'h00C;
	// Field positions in the shared control register.
	localparam int ITM_CTL_ENABLE_BIT = 7;
	localparam int ITM_CTL_WIDTH_BIT = 4;
	// Upper nibble of the prescaler register selects this timer's count clock.
	localparam int ITM_SEL_LSB = 4;
	// Reset values.
	localparam logic [7:0] ITM_CTL_RESET = 8'h00;
	localparam logic [7:0] ITM_CLK_SEL_RESET = 8'h11;
	localparam logic [15:0] ITM_COUNT_RESET = 16'h0000;
	// Clock select codes: 0..8 pick divide by 4 << code, 9 picks the edge input.
	localparam logic [3:0] ITM_SEL_EDGE = 4'h9;
	localparam int ITM_DIV_BITS = 10;
	// Divide taps 4 << 0 up to 4 << 8.
	localparam int ITM_NUM_DIV = 9;
	localparam int ITM_SYNC_STAGES = 2;
	localparam int ITM_MATCH_LANES = 2;
endpackage

// *** itm_interval_timer.sv ***
`timescale 1ns/1ns
// Operation
// - Width select bit 4 chooses 8-bit or 16-bit counting.
// - Counter increments on each count clock chosen by prescaler upper nibble.
// - Prescaler divides system clock by 4 up to 1024.
// - Setting enable clears counter on first count clock, then counts up.
// - Clearing enable zeroes counter at once and stops match signals.
// - Rewriting enable as one keeps counting without clearing.
// - On match, hold value until next count clock, then reset to zero.
// - Match interrupt request raised when counter reaches compare value.
// - Interrupt period is compare value plus one count clocks.
// - Reset clears counter and leaves counting stopped.
// - Compare register has no defined reset value.
// - Reset loads control register with zero.
// - Reset loads prescaler register with 11 hex.
// - Compare uses 8 bits in 8-bit width, 16 bits in 16-bit width.
// - Restart before next count clock starts from zero on that clock.
// - Counter is readable, writes to it are ignored.
// - Only upper nibbles govern this timer; lower nibbles held for another counter.
// - Count clock is divided system clock or detected edge.
// - Match detected only on counter increment.
// - Compare write in progress suppresses match detection.
module itm_interval_timer
	import itm_pkg::*;
#(
	parameter int DIV_BITS = ITM_DIV_BITS,
	parameter int SYNC_STAGES = ITM_SYNC_STAGES
)
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic edge_pin_in,
	output logic match_irq_out,
	output logic baud_tick_out,
	output logic [3:0] other_ctl_out,
	output logic [3:0] other_clk_sel_out
);

	logic [7:0] ctl_q;
	logic [7:0] clk_sel_q;
	logic [7:0] match_lane_q [ITM_MATCH_LANES];
	logic [15:0] match_value_q;
	logic [15:0] count_q;
	logic [DIV_BITS-1:0] div_q;
	logic [DIV_BITS-1:0] div_prev_q;
	logic [SYNC_STAGES-1:0] edge_sync_q;
	logic edge_prev_q;
	logic armed_q;
	logic restart_q;
	logic match_irq_q;
	logic baud_tick_q;
	logic [31:0] prdata_q;

	logic access;
	logic wr_ctl;
	logic wr_sel;
	logic wr_match;
	logic mapped;
	logic enable;
	logic wide;
	logic [3:0] sel;
	logic count_tick;
	logic [15:0] count_next;
	logic hit;
	logic [ITM_NUM_DIV-1:0] tap_tick;
	logic edge_tick;
	logic count_step;
	logic count_clear;
	logic match_event;
	logic read_setup;
	logic [31:0] read_word;

	// The taps need one prescaler bit beyond the slowest divide, and the edge
	// input needs two stages so that a metastable first stage never reaches logic.
	// Narrower settings would silently lose divide codes, so they are refused.
	if (DIV_BITS < ITM_NUM_DIV + 1)
	begin : g_div_check
		$error("Prescaler narrower than the slowest divide tap");
	end
	if (SYNC_STAGES < 2)
	begin : g_sync_check
		$error("Edge input needs at least two synchroniser stages");
	end

	// A transfer is taken in its access cycle only.
	assign access = psel_in && penable_in;
	assign mapped = (paddr_in == ITM_ADDR_TIMER_CTL) || (paddr_in == ITM_ADDR_CLK_SEL)
		|| (paddr_in == ITM_ADDR_MATCH) || (paddr_in == ITM_ADDR_COUNT);

	// The byte-wide registers only take a write whose strobe covers the low lane.
	// The compare register sorts its lanes out itself.
	always_comb
	begin
		wr_ctl = 1'b0;
		wr_sel = 1'b0;
		wr_match = 1'b0;
		if (access && pwrite_in)
		begin
			unique case (paddr_in)
				ITM_ADDR_TIMER_CTL: wr_ctl = pstrb_in[0];
				ITM_ADDR_CLK_SEL: wr_sel = pstrb_in[0];
				ITM_ADDR_MATCH: wr_match = 1'b1;
				default: wr_match = 1'b0;
			endcase
		end
	end
	// The slave never stretches a transfer.
	assign pready_out = 1'b1;
	// Writes to the counter are refused with an error rather than silently dropped.
	assign pslverr_out = access && (!mapped || (pwrite_in && paddr_in == ITM_ADDR_COUNT));

	assign enable = ctl_q[ITM_CTL_ENABLE_BIT];
	assign wide = ctl_q[ITM_CTL_WIDTH_BIT];
	assign sel = clk_sel_q[ITM_SEL_LSB +: 4];
	// The lower nibbles are passed through untouched to the other counter.
	assign other_ctl_out = ctl_q[3:0];
	assign other_clk_sel_out = clk_sel_q[3:0];

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctl_q <= ITM_CTL_RESET;
		end
		else if (wr_ctl)
		begin
			ctl_q <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			clk_sel_q <= ITM_CLK_SEL_RESET;
		end
		else if (wr_sel)
		begin
			clk_sel_q <= pwdata_in[7:0];
		end
	end

	// No reset: the compare value is meaningless until software loads it.
	// Byte lanes are separate so a 16-bit value can be loaded one byte at a time.
	genvar lane_idx;
	generate
		for (lane_idx = 0; lane_idx < ITM_MATCH_LANES; lane_idx++)
		begin : g_match_lane
			always_ff @(posedge clk_sys_in)
			begin
				if (wr_match && pstrb_in[lane_idx])
				begin
					match_lane_q[lane_idx] <= pwdata_in[lane_idx*8 +: 8];
				end
			end
		end
	endgenerate

	assign match_value_q = {match_lane_q[1], match_lane_q[0]};

	// Free-running prescaler; a tap's rising bit marks one count clock.
	// It is never cleared, so the first interval after a start may be short by up to a tick.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_q <= '0;
			div_prev_q <= '0;
		end
		else
		begin
			div_q <= div_q + 1'b1;
			div_prev_q <= div_q;
		end
	end

	// Only the last stage feeds logic; the earlier stages may still be settling.
	// The idle level of the pin is low, so a low reset value gives no false edge.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			edge_sync_q <= '0;
			edge_prev_q <= 1'b0;
		end
		else
		begin
			edge_sync_q <= {edge_sync_q[SYNC_STAGES-2:0], edge_pin_in};
			edge_prev_q <= edge_sync_q[SYNC_STAGES-1];
		end
	end

	// SYNC_STAGES clocks (two by default) pass from a pin edge to its tick.
	assign edge_tick = edge_sync_q[SYNC_STAGES-1] && !edge_prev_q;

	genvar tap_idx;
	generate
		for (tap_idx = 0; tap_idx < ITM_NUM_DIV; tap_idx++)
		begin : g_tap
			// Tap n rises once every 4 << n system clocks.
			assign tap_tick[tap_idx] = div_q[tap_idx + 1] && !div_prev_q[tap_idx + 1];
		end
	endgenerate

	// Codes above the edge code never tick, which parks the counter.
	always_comb
	begin
		count_tick = 1'b0;
		if (sel == ITM_SEL_EDGE)
		begin
			count_tick = edge_tick;
		end
		else if (sel < ITM_SEL_EDGE)
		begin
			count_tick = tap_tick[sel];
		end
	end

	// In the 8-bit width the upper byte stays zero, so the count wraps at FF.
	always_comb
	begin
		count_next = count_q + 16'h0001;
		if (!wide)
			count_next[15:8] = 8'h00;
	end

	// Match is only judged on the value produced by an increment.
	// Only the bytes in use take part, so stale upper compare bits never block a match.
	always_comb
	begin
		if (wide)
			hit = (count_next == match_value_q);
		else
			hit = (count_next[7:0] == match_value_q[7:0]);
	end

	// A tick either loads zero (first tick after a start, or the tick after a match)
	// or steps the count; the two never fall together.
	assign count_clear = count_tick && (!armed_q || restart_q);
	assign count_step = count_tick && armed_q && !restart_q;
	// A compare write in the same cycle masks the match, so rewriting a value never fires.
	// Loading zero is not an increment, so a compare value of zero is matched only when the count wraps to zero.
	assign match_event = enable && count_step && hit && !wr_match;

	// Clearing the enable wins over a tick in the same cycle; the count reads zero at once.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			count_q <= ITM_COUNT_RESET;
		end
		else if (!enable)
		begin
			count_q <= ITM_COUNT_RESET;
		end
		else if (count_clear)
		begin
			count_q <= ITM_COUNT_RESET;
		end
		else if (count_step)
		begin
			count_q <= count_next;
		end
	end

	// Armed marks that the first tick after a start has already loaded zero.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			armed_q <= 1'b0;
		end
		else if (!enable)
		begin
			armed_q <= 1'b0;
		end
		else if (count_tick)
		begin
			armed_q <= 1'b1;
		end
	end

	// Restart is a pending clear: the matched value stands until the next tick.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			restart_q <= 1'b0;
		end
		else if (!enable || count_clear)
		begin
			restart_q <= 1'b0;
		end
		else if (count_step)
		begin
			restart_q <= hit && !wr_match;
		end
	end

	// Both strobes are registered so a serial interface sees a clean one-cycle pulse.
	// They carry the same event; keeping them apart lets each fan out on its own.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			match_irq_q <= 1'b0;
		end
		else
		begin
			match_irq_q <= match_event;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			baud_tick_q <= 1'b0;
		end
		else
		begin
			baud_tick_q <= match_event;
		end
	end

	assign match_irq_out = match_irq_q;
	assign baud_tick_out = baud_tick_q;

	// Read data is captured in the setup cycle so it stands for the whole access cycle.
	assign read_setup = psel_in && !penable_in && !pwrite_in;

	// Unmapped offsets read as zero.
	always_comb
	begin
		read_word = 32'h0000_0000;
		unique case (paddr_in)
			ITM_ADDR_TIMER_CTL: read_word = {24'h000000, ctl_q};
			ITM_ADDR_CLK_SEL: read_word = {24'h000000, clk_sel_q};
			ITM_ADDR_MATCH: read_word = {16'h0000, match_value_q};
			ITM_ADDR_COUNT: read_word = {16'h0000, count_q};
			default: read_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prdata_q <= 32'h0000_0000;
		end
		else if (read_setup)
		begin
			prdata_q <= read_word;
		end
	end

	assign prdata_out = prdata_q;

endmodule

// *** itm_checker.sv ***
`timescale 1ns/1ns
module itm_checker
	import itm_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	input wire logic match_irq_out,
	input wire logic baud_tick_out,
	input wire logic [3:0] other_ctl_out,
	input wire logic [3:0] other_clk_sel_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire acc = psel_in && penable_in;
	wire wr0 = acc && pwrite_in && pstrb_in[0];
	err_phase_a: assert property (pslverr_out |-> acc)
		else $error("stray pslverr");
	count_write_a: assert property (wr0 && paddr_in == ITM_ADDR_COUNT |-> pslverr_out)
		else $error("count write taken");
	ctl_ok_a: assert property (acc && paddr_in == ITM_ADDR_TIMER_CTL |-> !pslverr_out)
		else $error("ctl refused");
	unmapped_a: assert property (acc && !pwrite_in && paddr_in == 12'h010 |-> pslverr_out && prdata_out == 0)
		else $error("unmapped accepted");
	pulse_pair_a: assert property (baud_tick_out == match_irq_out)
		else $error("tick differs");
	pulse_one_a: assert property (match_irq_out |=> !match_irq_out)
		else $error("long pulse");
	ctl_low_a: assert property (wr0 && paddr_in == ITM_ADDR_TIMER_CTL |=>
		other_ctl_out == $past(pwdata_in[3:0])) else $error("ctl nibble");
	sel_low_a: assert property (wr0 && paddr_in == ITM_ADDR_CLK_SEL |=>
		other_clk_sel_out == $past(pwdata_in[3:0])) else $error("sel nibble");
endmodule
bind itm_interval_timer itm_checker u_chk (.*);

// *** tb.sv ***
`timescale 1ns/1ns
module tb
	import itm_pkg::*;
;
	logic clk_sys_in = 1'h0;
	logic rst_in = 1'h1;
	logic psel_in = 1'h0;
	logic penable_in = 1'h0;
	logic pwrite_in = 1'h0;
	logic [11:0] paddr_in = 12'h0;
	logic [31:0] pwdata_in = 32'h0;
	logic [3:0] pstrb_in = 4'hF;
	logic edge_pin_in = 1'h0;
	logic [31:0] prdata_out, rd;
	logic pready_out, pslverr_out, match_irq_out, baud_tick_out;
	logic err;
	logic [3:0] other_ctl_out, other_clk_sel_out;
	int bad_count = 0, samples_checked = 0, cyc = 0, irq_seen = 0;
	itm_interval_timer dut (.*);
	always @(negedge clk_sys_in)
	begin
		if (match_irq_out === 1'h1)
			irq_seen <= irq_seen + 1;
	end
	always #5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in)
	begin
		cyc <= cyc + 1;
		if (cyc % 4 == 0)
			edge_pin_in <= ~edge_pin_in;
	end
	task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'h1;
		@(posedge clk_sys_in);
		while (pready_out !== 1'h1)
			@(posedge clk_sys_in);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			$display("[FAIL] %s exp %h got %h", n, e, s);
			bad_count++;
		end
	endtask
	task automatic wq(output int t);
		int i;
		i = 0;
		do
			@(negedge clk_sys_in);
		while (match_irq_out !== 1'h1 && ++i < 20000);
		if (i >= 20000)
		begin
			$display("[FAIL] irq timeout exp 1 got 0");
			bad_count++;
		end
		t = cyc;
	endtask
	function automatic int per(int k, int n);
		return (n + 1) * (k == 9 ? 8 : 4 << k);
	endfunction
	task automatic finish_test;
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		int a, b, n, k, lo;
		void'($urandom(32'hB04B));
		repeat (6) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		ap(1'h0, ITM_ADDR_TIMER_CTL, 0);
		chk("ctl", 32'h0, rd);
		ap(1'h0, ITM_ADDR_CLK_SEL, 0);
		chk("sel", 32'h11, rd);
		ap(1'h1, ITM_ADDR_COUNT, 32'h55);
		chk("wr err", 32'h1, 32'(err));
		ap(1'h0, ITM_ADDR_COUNT, 0);
		chk("wr kept", 32'h0, rd);
		ap(1'h0, 12'h010, 0);
		chk("unmapped err", 32'h1, 32'(err));
		chk("unmapped rd", 32'h0, rd);
		for (k = 0; k < 10; k++)
		begin
			n = $urandom_range(5, 1);
			lo = $urandom_range(15, 0);
			ap(1'h1, ITM_ADDR_CLK_SEL, 32'(k * 16 + lo));
			ap(1'h1, ITM_ADDR_MATCH, 32'({8'($urandom), 8'(n)}));
			ap(1'h1, ITM_ADDR_TIMER_CTL, 32'h80);
			wq(a);
			wq(b);
			chk("per", per(k, n), b - a);
			ap(1'h1, ITM_ADDR_TIMER_CTL, 32'h0);
			ap(1'h0, ITM_ADDR_COUNT, 0);
			chk("stop", 32'h0, rd);
		end
		ap(1'h1, ITM_ADDR_CLK_SEL, 32'h0);
		ap(1'h1, ITM_ADDR_MATCH, 32'h103);
		ap(1'h1, ITM_ADDR_TIMER_CTL, 32'h90);
		wq(a);
		wq(b);
		chk("p16", per(0, 259), b - a);
		repeat (20) @(posedge clk_sys_in);
		ap(1'h0, ITM_ADDR_COUNT, 0);
		n = rd;
		ap(1'h1, ITM_ADDR_TIMER_CTL, 32'h90);
		ap(1'h0, ITM_ADDR_COUNT, 0);
		chk("keep", 32'h1, 32'(rd > n));
		ap(1'h1, ITM_ADDR_TIMER_CTL, 32'h0);
		ap(1'h1, ITM_ADDR_CLK_SEL, 32'h30);
		ap(1'h1, ITM_ADDR_MATCH, 32'hFF);
		ap(1'h1, ITM_ADDR_TIMER_CTL, 32'h80);
		repeat (100) @(posedge clk_sys_in);
		ap(1'h0, ITM_ADDR_COUNT, 0);
		n = irq_seen;
		ap(1'h1, ITM_ADDR_MATCH, rd);
		repeat (200) @(posedge clk_sys_in);
		chk("same value", n, irq_seen);
		@(posedge clk_sys_in);
		rst_in <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		ap(1'h0, ITM_ADDR_TIMER_CTL, 0);
		chk("rst ctl", 32'h0, rd);
		ap(1'h0, ITM_ADDR_CLK_SEL, 0);
		chk("rst sel", 32'h11, rd);
		ap(1'h0, ITM_ADDR_COUNT, 0);
		chk("rst count", 32'h0, rd);
		finish_test;
	end
	initial
	begin
		#900000;
		bad_count++;
		finish_test;
	end
endmodule
